//--- rtl/shs_cfg.svh
`ifndef SHS_CFG_SVH
`define SHS_CFG_SVH
// Operation
// - decode opcode 31, extended 439 as update-indexed halfword
// - store low halfword at base+index, update base
// - bad reserved bits or zero base: no trap
// - decode opcode 31, extended 407, no register change
// - base field zero means base value zero
// - opcode 47, sign-extended 16-bit displacement
// - store source..31 ascending, address step four
// - decode opcode 31, extended 725, count in index field
// - immediate string address is base-or-zero only
// - immediate count zero means 32 bytes
// - string registers wrap from 31 to 0
// - string bytes leave most-significant first
// - decode opcode 31, extended 661, base plus index
// - indexed string count from transfer count field
// - zero transfer count: no write, no fault
// - zero count probe may still machine-check
// - zone protection fault raises data storage
// - no-access blocks user only, read-only blocks all
// - no valid translation raises translation miss

// instruction encodings
`define SHS_OPC_X 6'h1f
`define SHS_OPC_STMW 6'h2f
`define SHS_XO_STHUX 10'h1b7
`define SHS_XO_STHX 10'h197
`define SHS_XO_STSWI 10'h2d5
`define SHS_XO_STSWX 10'h295
// register byte addresses
`define SHS_ADR_CTRL 8'h00
`define SHS_ADR_TBC 8'h04
`define SHS_ADR_INSTR 8'h08
`define SHS_ADR_STAT 8'h0c
`define SHS_ADR_FAULT 8'h10
// control fields and reset values
`define SHS_CTRL_RELOC 0
`define SHS_CTRL_USER 1
`define SHS_RST_CTRL 2'h0
`define SHS_RST_TBC 7'h00
// zone encodings
`define SHS_ZONE_NOACC 2'h0
`define SHS_ZONE_RO 2'h1
// counts and sizes
`define SHS_NREG 7'h20
`define SHS_WORD_STEP 32'h4
`define SHS_SZ_PROBE 3'h0
`define SHS_SZ_BYTE 3'h1
`define SHS_SZ_HALF 3'h2
`define SHS_SZ_WORD 3'h4
// bus responses
`define SHS_RESP_OK 2'h0
`define SHS_RESP_ERR 2'h2
`endif

//--- rtl/shs_pkg.sv
package shs_pkg;
  // decoded operation
  typedef enum logic [2:0] {
    SHS_OP_NONE = 3'h0,
    SHS_OP_STHUX = 3'h1,
    SHS_OP_STHX = 3'h2,
    SHS_OP_STMW = 3'h3,
    SHS_OP_STSWI = 3'h4,
    SHS_OP_STSWX = 3'h5
  } shs_op_t;
  // sequencer states, gray along the path
  typedef enum logic [1:0] {
    SHS_IDLE = 2'h0,
    SHS_CHECK = 2'h1,
    SHS_STORE = 2'h3,
    SHS_WBACK = 2'h2
  } shs_st_t;
  // exception codes
  typedef enum logic [1:0] {
    SHS_EXC_NONE = 2'h0,
    SHS_EXC_DSI = 2'h1,
    SHS_EXC_DTLB = 2'h2,
    SHS_EXC_MCHK = 2'h3
  } shs_exc_t;
endpackage

//--- rtl/shs_if.sv
`timescale 1ns/10ps
// decode and protection results toward the sequencer
interface shs_if;
  import shs_pkg::*;
  logic [31:0] instr; // instruction under decode
  shs_op_t op; // decoded operation
  logic [4:0] rs; // source_reg_field
  logic [4:0] ra; // base_reg_field
  logic [4:0] rb; // index_reg_field or count
  logic [15:0] disp; // displacement field
  logic reloc; // data relocation on
  logic user; // user mode
  logic hit; // translation found
  logic [1:0] zone; // zone of the access
  logic dsi; // zone forbids store
  logic miss; // translation miss
  modport dec (input instr, output op, rs, ra, rb, disp);
  modport chk (input reloc, user, hit, zone, output dsi, miss);
endinterface

//--- rtl/shs_decode.sv
`timescale 1ns/10ps
`include "shs_cfg.svh"
// pure decode of the store group
module shs_decode (
  shs_if.dec bus // decode side of the carrier
);
  import shs_pkg::*;
  // ===================================================
  // field split and opcode match
  always_comb begin
    logic [5:0] opc;
    logic [9:0] xo;
    opc = bus.instr[31:26];
    xo = bus.instr[10:1];
    bus.rs = bus.instr[25:21];
    bus.ra = bus.instr[20:16];
    bus.rb = bus.instr[15:11];
    bus.disp = bus.instr[15:0];
    bus.op = SHS_OP_NONE;
    // reserved bit 0 is not looked at: no trap is raised for it
    if (opc == `SHS_OPC_STMW) begin
      bus.op = SHS_OP_STMW;
    end else if (opc == `SHS_OPC_X) begin
      case (xo)
        `SHS_XO_STHUX: bus.op = SHS_OP_STHUX;
        `SHS_XO_STHX: bus.op = SHS_OP_STHX;
        `SHS_XO_STSWI: bus.op = SHS_OP_STSWI;
        `SHS_XO_STSWX: bus.op = SHS_OP_STSWX;
        default: bus.op = SHS_OP_NONE;
      endcase
    end
  end
endmodule

//--- rtl/shs_prot.sv
`timescale 1ns/10ps
`include "shs_cfg.svh"
// zone and translation check for one store access
module shs_prot (
  shs_if.chk bus // check side of the carrier
);
  // ===================================================
  // fault decision; a miss outranks zone since no zone exists
  always_comb begin
    logic forbid;
    forbid = (bus.zone == `SHS_ZONE_RO) ||
      (bus.zone == `SHS_ZONE_NOACC && bus.user);
    bus.miss = bus.reloc && !bus.hit;
    bus.dsi = bus.reloc && bus.hit && forbid;
  end
endmodule

//--- rtl/shs_exec.sv
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "shs_cfg.svh"
// store group sequencer with its register file and bus slave
module shs_exec (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic awvalid_i, // write address valid
  output logic awready_o, // write address ready
  input wire logic [7:0] awaddr_i, // write byte address
  input wire logic wvalid_i, // write data valid
  output logic wready_o, // write data ready
  input wire logic [31:0] wdata_i, // write data
  input wire logic [3:0] wstrb_i, // byte enables
  output logic bvalid_o, // write response valid
  input wire logic bready_i, // write response ready
  output logic [1:0] bresp_o, // write response
  input wire logic arvalid_i, // read address valid
  output logic arready_o, // read address ready
  input wire logic [7:0] araddr_i, // read byte address
  output logic rvalid_o, // read data valid
  input wire logic rready_i, // read data ready
  output logic [31:0] rdata_o, // read data
  output logic [1:0] rresp_o, // read response
  output logic mem_req_o, // store request, held to ack
  output logic [31:0] mem_addr_o, // effective_address
  output logic [31:0] mem_data_o, // right-aligned data
  output logic [2:0] mem_size_o, // bytes, zero for probe
  input wire logic mem_ack_i, // store done
  input wire logic mem_bus_err_i, // bus error with ack
  input wire logic xlat_hit_i, // translation for addr
  input wire logic [1:0] xlat_zone_i, // zone for addr
  output logic exc_valid_o, // exception pulse
  output shs_pkg::shs_exc_t exc_code_o, // exception kind
  output logic busy_o // instruction in flight
);
  import shs_pkg::*;

  // ===================================================
  // state record
  typedef struct packed {
    shs_st_t st; // sequencer state
    logic go; // instruction waiting
    logic [31:0] instr; // instruction word
    shs_op_t op; // operation in flight
    logic [4:0] rs; // source_reg_field
    logic [4:0] ra; // base_reg_field
    logic [4:0] rr; // register being stored
    logic [6:0] cnt; // items left
    logic [1:0] bi; // byte within register
    logic probe; // zero-count touch only
    logic [31:0] ea; // effective_address
    logic [31:0][31:0] general_reg; // general_reg file
    logic [1:0] ctrl; // user and relocation
    logic [6:0] tbc; // transfer_byte_count_field
    logic unk; // last word not in group
    logic [31:0] fault; // last faulting address
    logic aw_got; // address latched
    logic w_got; // data latched
    logic [7:0] awaddr; // latched address
    logic [31:0] wdata; // latched data
    logic [3:0] wstrb; // latched strobes
    logic awready; // bus ready flops
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic req; // store request
    logic [31:0] maddr;
    logic [31:0] mdata;
    logic [2:0] msize;
    logic exc_valid;
    shs_exc_t exc;
    logic busy;
  } shs_state_t;

  shs_state_t s_q; // registered state
  shs_state_t s_d; // next state

  // ===================================================
  // decode and check helpers
  shs_if u_if ();
  shs_decode u_dec (.bus(u_if.dec));
  shs_prot u_prot (.bus(u_if.chk));
  assign u_if.instr = s_q.instr;
  assign u_if.reloc = s_q.ctrl[`SHS_CTRL_RELOC];
  assign u_if.user = s_q.ctrl[`SHS_CTRL_USER];
  assign u_if.hit = xlat_hit_i;
  assign u_if.zone = xlat_zone_i;

  // register read mux, shared by reads and strobe merge
  function automatic logic [31:0] rd_reg(shs_state_t s,
                                        logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a[7]) begin
      v = s.general_reg[a[6:2]];
    end else begin
      case (a)
        `SHS_ADR_CTRL: v = {30'h0, s.ctrl};
        `SHS_ADR_TBC: v = {25'h0, s.tbc};
        `SHS_ADR_INSTR: v = s.instr;
        `SHS_ADR_STAT: v = {28'h0, s.unk, s.exc, s.busy};
        `SHS_ADR_FAULT: v = s.fault;
        default: v = 32'h0;
      endcase
    end
    return v;
  endfunction

  // ===================================================
  // next-state logic
  always_comb begin
    logic [31:0] mrg;
    logic [31:0] base;
    logic [7:0] wa;
    logic [7:0] ra8;
    logic idle;
    mrg = 32'h0;
    base = 32'h0;
    wa = {s_q.awaddr[7:2], 2'h0};
    ra8 = {araddr_i[7:2], 2'h0};
    idle = (s_q.st == SHS_IDLE) && !s_q.go;
    s_d = s_q;
    s_d.exc_valid = 1'b0;
    // write address and data are taken in either order
    if (awvalid_i && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr_i;
    end
    if (wvalid_i && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata_i;
      s_d.wstrb = wstrb_i;
    end
    if (s_q.bvalid && bready_i) begin
      s_d.bvalid = 1'b0;
    end
    // both halves here: commit the write and answer
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      mrg = rd_reg(s_q, wa);
      for (int i = 0; i < 4; i++) begin
        if (s_q.wstrb[i]) begin
          mrg[8*i +: 8] = s_q.wdata[8*i +: 8];
        end
      end
      s_d.bresp = `SHS_RESP_OK;
      if (wa[7]) begin
        // file is frozen while an instruction runs
        if (idle) begin
          s_d.general_reg[wa[6:2]] = mrg;
        end else begin
          s_d.bresp = `SHS_RESP_ERR;
        end
      end else begin
        case (wa)
          `SHS_ADR_CTRL: s_d.ctrl = mrg[1:0];
          `SHS_ADR_TBC: s_d.tbc = mrg[6:0];
          `SHS_ADR_INSTR: begin
            if (idle) begin
              s_d.instr = mrg;
              s_d.go = 1'b1;
            end else begin
              s_d.bresp = `SHS_RESP_ERR;
            end
          end
          default: s_d.bresp = `SHS_RESP_ERR;
        endcase
      end
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
    end
    // read channel: one beat, answered the next cycle
    if (s_q.rvalid && rready_i) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid_i && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_reg(s_q, ra8);
      s_d.rresp = (ra8[7] || ra8 <= `SHS_ADR_FAULT) ?
        `SHS_RESP_OK : `SHS_RESP_ERR;
    end

    // sequencer
    case (s_q.st)
      SHS_IDLE: begin
        if (s_q.go) begin
          s_d.go = 1'b0;
          s_d.op = u_if.op;
          s_d.rs = u_if.rs;
          s_d.ra = u_if.ra;
          s_d.rr = u_if.rs;
          s_d.bi = 2'h0;
          s_d.probe = 1'b0;
          s_d.unk = (u_if.op == SHS_OP_NONE);
          // update form keeps the named base even for field 0
          if (u_if.ra != 5'h0 || u_if.op == SHS_OP_STHUX) begin
            base = s_q.general_reg[u_if.ra];
          end
          case (u_if.op)
            SHS_OP_STHUX, SHS_OP_STHX: begin
              s_d.ea = base + s_q.general_reg[u_if.rb];
              s_d.cnt = 7'h1;
            end
            SHS_OP_STMW: begin
              s_d.ea = base + {{16{u_if.disp[15]}}, u_if.disp};
              s_d.cnt = `SHS_NREG - {2'h0, u_if.rs};
            end
            SHS_OP_STSWI: begin
              s_d.ea = base;
              s_d.cnt = (u_if.rb == 5'h0) ? `SHS_NREG :
                {2'h0, u_if.rb};
            end
            SHS_OP_STSWX: begin
              s_d.ea = base + s_q.general_reg[u_if.rb];
              s_d.cnt = s_q.tbc;
              s_d.probe = (s_q.tbc == 7'h0);
            end
            default: s_d.cnt = 7'h0;
          endcase
          s_d.maddr = s_d.ea;
          if (u_if.op != SHS_OP_NONE) begin
            s_d.st = SHS_CHECK;
          end
        end
      end
      SHS_CHECK: begin
        if (u_if.miss || u_if.dsi) begin
          s_d.st = SHS_IDLE;
          // a zero-count probe that fails checks just ends quietly
          if (!s_q.probe) begin
            s_d.exc_valid = 1'b1;
            s_d.exc = u_if.miss ? SHS_EXC_DTLB : SHS_EXC_DSI;
            s_d.fault = s_q.ea;
          end
        end else begin
          s_d.st = SHS_STORE;
          s_d.req = 1'b1;
          case (s_q.op)
            SHS_OP_STHUX, SHS_OP_STHX: begin
              s_d.mdata = {16'h0, s_q.general_reg[s_q.rs][15:0]};
              s_d.msize = `SHS_SZ_HALF;
            end
            SHS_OP_STMW: begin
              s_d.mdata = s_q.general_reg[s_q.rr];
              s_d.msize = `SHS_SZ_WORD;
            end
            default: begin
              s_d.mdata = {24'h0,
                s_q.general_reg[s_q.rr][{~s_q.bi, 3'h0} +: 8]};
              s_d.msize = `SHS_SZ_BYTE;
            end
          endcase
          if (s_q.probe) begin
            s_d.mdata = 32'h0;
            s_d.msize = `SHS_SZ_PROBE;
          end
        end
      end
      SHS_STORE: begin
        if (mem_ack_i) begin
          s_d.req = 1'b0;
          s_d.st = SHS_IDLE;
          if (mem_bus_err_i) begin
            s_d.exc_valid = 1'b1;
            s_d.exc = SHS_EXC_MCHK;
            s_d.fault = s_q.ea;
          end else if (s_q.op == SHS_OP_STHUX) begin
            s_d.st = SHS_WBACK;
          end else if (s_q.probe || s_q.cnt == 7'h1) begin
            s_d.st = SHS_IDLE;
          end else if (s_q.op == SHS_OP_STMW) begin
            s_d.rr = s_q.rr + 5'h1;
            s_d.ea = s_q.ea + `SHS_WORD_STEP;
            s_d.cnt = s_q.cnt - 7'h1;
            s_d.st = SHS_CHECK;
          end else begin
            // five-bit index wraps 31 to 0 by itself
            s_d.bi = s_q.bi + 2'h1;
            if (s_q.bi == 2'h3) begin
              s_d.rr = s_q.rr + 5'h1;
            end
            s_d.ea = s_q.ea + 32'h1;
            s_d.cnt = s_q.cnt - 7'h1;
            s_d.st = SHS_CHECK;
          end
          s_d.maddr = s_d.ea;
        end
      end
      SHS_WBACK: begin
        s_d.general_reg[s_q.ra] = s_q.ea;
        s_d.st = SHS_IDLE;
      end
      default: s_d.st = SHS_IDLE;
    endcase
    s_d.busy = (s_d.st != SHS_IDLE) || s_d.go;
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // ===================================================
  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.ctrl <= `SHS_RST_CTRL;
      s_q.tbc <= `SHS_RST_TBC;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign awready_o = s_q.awready;
  assign wready_o = s_q.wready;
  assign bvalid_o = s_q.bvalid;
  assign bresp_o = s_q.bresp;
  assign arready_o = s_q.arready;
  assign rvalid_o = s_q.rvalid;
  assign rdata_o = s_q.rdata;
  assign rresp_o = s_q.rresp;
  assign mem_req_o = s_q.req;
  assign mem_addr_o = s_q.maddr;
  assign mem_data_o = s_q.mdata;
  assign mem_size_o = s_q.msize;
  assign exc_valid_o = s_q.exc_valid;
  assign exc_code_o = s_q.exc;
  assign busy_o = s_q.busy;

  // ===================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic start; // instruction taken this cycle
  logic str_op; // string operation in flight
  logic ack_ok; // clean store completion
  assign start = (s_q.st == SHS_IDLE) && s_q.go;
  assign str_op = (s_q.op == SHS_OP_STSWI) ||
    (s_q.op == SHS_OP_STSWX);
  assign ack_ok = (s_q.st == SHS_STORE) && mem_ack_i &&
    !mem_bus_err_i;

  sthux_dec_a: assert property (start &&
    s_q.instr[31:26] == 6'h1f && s_q.instr[10:1] == 10'h1b7
    |=> s_q.op == SHS_OP_STHUX && s_q.st == SHS_CHECK)
    else $error("update halfword store not decoded");
  wback_base_a: assert property (
    ack_ok && s_q.op == SHS_OP_STHUX
    |=> s_q.st == SHS_WBACK ##1 s_q.general_reg[s_q.ra] == s_q.ea)
    else $error("base not updated after halfword store");
  half_data_a: assert property (s_q.req &&
    (s_q.op == SHS_OP_STHUX || s_q.op == SHS_OP_STHX)
    |-> mem_size_o == 3'h2 &&
    mem_data_o == {16'h0, s_q.general_reg[s_q.rs][15:0]})
    else $error("halfword store data wrong");
  rsv_notrap_a: assert property (start &&
    u_if.op != SHS_OP_NONE && s_q.instr[0]
    |=> s_q.st == SHS_CHECK && !exc_valid_o)
    else $error("reserved bit stopped execution");
  sthx_base_a: assert property (start &&
    u_if.op == SHS_OP_STHX && u_if.ra == 5'h0
    |=> s_q.ea == s_q.general_reg[s_q.instr[15:11]])
    else $error("zero base field not read as zero");
  stmw_sext_a: assert property (start &&
    u_if.op == SHS_OP_STMW && u_if.ra == 5'h0
    |=> s_q.ea == {{16{s_q.instr[15]}}, s_q.instr[15:0]} &&
    s_q.cnt == 7'h20 - {2'h0, s_q.rs})
    else $error("multiple store start wrong");
  stmw_step_a: assert property (ack_ok &&
    s_q.op == SHS_OP_STMW && s_q.cnt != 7'h1
    |=> s_q.ea == $past(s_q.ea) + 32'h4 &&
    s_q.rr == $past(s_q.rr) + 5'h1)
    else $error("multiple store step wrong");
  cnt_zero_a: assert property (start &&
    u_if.op == SHS_OP_STSWI && u_if.rb == 5'h0
    |=> s_q.cnt == 7'h20)
    else $error("zero immediate count not 32");
  str_byte_a: assert property (s_q.req && str_op &&
    !s_q.probe |-> mem_size_o == 3'h1 && mem_data_o[7:0] ==
    s_q.general_reg[s_q.rr][{~s_q.bi, 3'h0} +: 8])
    else $error("string byte order wrong");
  str_wrap_a: assert property (ack_ok && str_op &&
    s_q.bi == 2'h3 && s_q.rr == 5'h1f && s_q.cnt != 7'h1
    |=> s_q.rr == 5'h0)
    else $error("string register did not wrap");
  tbc_cnt_a: assert property (start &&
    u_if.op == SHS_OP_STSWX |=> s_q.cnt == $past(s_q.tbc))
    else $error("indexed string count not taken");
  probe_quiet_a: assert property (s_q.probe |->
    !(s_q.req && mem_size_o != 3'h0) &&
    !(exc_valid_o && exc_code_o != SHS_EXC_MCHK))
    else $error("zero count store wrote or faulted");
  probe_mc_a: assert property (s_q.probe &&
    s_q.st == SHS_STORE && mem_ack_i && mem_bus_err_i
    |=> exc_valid_o && exc_code_o == SHS_EXC_MCHK)
    else $error("probe bus error not reported");
  ro_priv_a: assert property (s_q.st == SHS_CHECK &&
    !s_q.probe && s_q.ctrl == 2'h1 && xlat_hit_i &&
    xlat_zone_i == 2'h1 |=> exc_valid_o &&
    exc_code_o == SHS_EXC_DSI)
    else $error("read-only zone not enforced");
  noacc_priv_a: assert property (s_q.st == SHS_CHECK &&
    s_q.ctrl == 2'h1 && xlat_hit_i && xlat_zone_i == 2'h0
    |=> s_q.st == SHS_STORE && !exc_valid_o)
    else $error("no-access zone blocked privileged");
  miss_a: assert property (s_q.st == SHS_CHECK &&
    !s_q.probe && s_q.ctrl[0] && !xlat_hit_i
    |=> exc_valid_o && exc_code_o == SHS_EXC_DTLB)
    else $error("translation miss not raised");

  stmw_done_c: cover property (ack_ok &&
    s_q.op == SHS_OP_STMW && s_q.cnt == 7'h1);
  wrap_c: cover property (ack_ok && str_op &&
    s_q.rr == 5'h1f && s_q.bi == 2'h3);
  probe_c: cover property (s_q.probe && mem_ack_i);
  wback_c: cover property (s_q.st == SHS_WBACK);
endmodule

//--- bench/shs_mem.sv
`timescale 1ns/10ps
// ==========
// store side memory: acks after a random wait, logs every access
module shs_mem (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic req_i, // store request
  input wire logic [31:0] addr_i, // access address
  input wire logic [31:0] data_i, // right aligned data
  input wire logic [2:0] size_i, // bytes, zero probe
  input wire logic err_i, // bus error wanted on ack
  output logic ack_o, // one cycle done pulse
  output logic err_o // bus error, valid with ack
);
  logic [1:0] wait_q; // cycles left before the ack
  logic [66:0] log_q[$]; // size, address, data per access
  // error line toggles outside the ack so a stale level is never seen
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      ack_o <= 1'b0;
      err_o <= !err_o;
      if (req_i && !ack_o && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (req_i && !ack_o) begin
        ack_o <= 1'b1;
        err_o <= err_i;
        log_q.push_back({size_i, addr_i, data_i});
        wait_q <= 2'($urandom);
      end
    end
  end
endmodule

//--- bench/store_halfword_multiple_string_exec_bench.sv
`timescale 1ns/10ps
`include "shs_cfg.svh"
// ==========
// random and corner stores checked against a shadow register file
module store_halfword_multiple_string_exec_bench;
  import shs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
  logic arvalid_i, arready_o, rvalid_o, rready_i, mem_req_o, mem_ack_i;
  logic mem_bus_err_i, xlat_hit_i, exc_valid_o, busy_o, berr, f;
  logic [7:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o, mem_addr_o, mem_data_o, rd, x, ins;
  logic [31:0] gm[32]; // shadow of the general registers
  logic [3:0] wstrb_i;
  logic [1:0] bresp_o, rresp_o, xlat_zone_i, rr, br;
  logic [2:0] mem_size_o;
  shs_exc_t exc_code_o, exc_c;
  logic [66:0] exp_q[$]; // expected accesses
  int bad_count = 0;
  int n_checks = 0;
  int exc_n;
  always #2.5 clk_i = !clk_i;
  shs_exec shs_exec_inst (.clk_i, .rst_i, .awvalid_i, .awready_o, .awaddr_i,
    .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o,
    .arvalid_i, .arready_o, .araddr_i, .rvalid_o, .rready_i, .rdata_o,
    .rresp_o, .mem_req_o, .mem_addr_o, .mem_data_o, .mem_size_o, .mem_ack_i,
    .mem_bus_err_i, .xlat_hit_i, .xlat_zone_i, .exc_valid_o, .exc_code_o,
    .busy_o);
  shs_mem shs_mem_inst (.clk_i, .rst_i, .req_i(mem_req_o),
    .addr_i(mem_addr_o), .data_i(mem_data_o), .size_i(mem_size_o),
    .err_i(berr), .ack_o(mem_ack_i), .err_o(mem_bus_err_i));
  // exception pulses counted, code of the last one kept
  always @(posedge clk_i) begin
    if (exc_valid_o === 1'b1) begin
      exc_n++;
      exc_c = exc_code_o;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [66:0] seen, logic [66:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang();
    bad_count++;
    final_report();
  endtask
  // both write channels offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wready_o === 1'b1) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1 && n < 100);
    br = bresp_o;
    bready_i <= 1'b0;
    if (n >= 100) hang();
  endtask
  task automatic rdr(logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1 && n < 100);
    rd = rdata_o;
    rr = rresp_o;
    rready_i <= 1'b0;
    if (n >= 100) hang();
  endtask
  function automatic logic [31:0] xf(int s, a, b, input logic [9:0] xo);
    return {`SHS_OPC_X, 5'(s), 5'(a), 5'(b), xo, 1'b0};
  endfunction
  // keeps only the bytes that the access size covers
  function automatic logic [66:0] mask(logic [66:0] e);
    logic [63:0] m;
    m = (64'h1 << (8 * e[66:64])) - 64'h1;
    return {e[66:32], e[31:0] & m[31:0]};
  endfunction
  // expected accesses of one instruction from the shadow registers
  function automatic void build(logic [31:0] i, logic [6:0] tbc);
    logic [4:0] s, a, b;
    logic [31:0] ea;
    int n;
    s = i[25:21];
    a = i[20:16];
    b = i[15:11];
    ea = (a == 5'h0) ? 32'h0 : gm[a];
    exp_q.delete();
    if (i[31:26] == `SHS_OPC_STMW) begin
      ea = ea + {{16{i[15]}}, i[15:0]};
      for (int r = s; r < 32; r++) begin
        exp_q.push_back({3'h4, ea + 32'(4 * (r - s)), gm[r]});
      end
    end else if (i[10:1] inside {`SHS_XO_STHX, `SHS_XO_STHUX}) begin
      if (i[10:1] == `SHS_XO_STHUX) ea = gm[a];
      ea = ea + gm[b];
      exp_q.push_back({3'h2, ea, 16'h0, gm[s][15:0]});
      if (i[10:1] == `SHS_XO_STHUX) gm[a] = ea;
    end else begin
      n = (i[10:1] == `SHS_XO_STSWX) ? tbc : ((b == 5'h0) ? 32 : b);
      if (i[10:1] == `SHS_XO_STSWX) ea = ea + gm[b];
      if (n == 0) exp_q.push_back({3'h0, ea, 32'h0});
      for (int k = 0; k < n; k++) begin
        exp_q.push_back({3'h1, ea + 32'(k), 24'h0,
          gm[5'(s + k / 4)][31 - 8 * (k % 4) -: 8]});
      end
    end
  endfunction
  task automatic run(logic [31:0] i, logic [6:0] tbc, bit keep, int code);
    int n;
    build(i, tbc);
    if (!keep) exp_q.delete();
    shs_mem_inst.log_q.delete();
    exc_n = 0;
    wr(`SHS_ADR_INSTR, i);
    chk("issue resp", br, `SHS_RESP_OK);
    n = 0;
    while (busy_o !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000) hang();
    @(posedge clk_i);
    chk("count", shs_mem_inst.log_q.size(), exp_q.size());
    foreach (exp_q[k])
      chk("store", mask(shs_mem_inst.log_q[k]), exp_q[k]);
    chk("exceptions", exc_n, code != 0);
    if (code != 0) chk("code", exc_c, code);
  endtask
  initial begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, berr} = 6'h0;
    {awaddr_i, araddr_i, wdata_i} = 48'h0;
    wstrb_i = 4'hf;
    xlat_hit_i = 1'b1;
    xlat_zone_i = 2'h2;
    void'($urandom(32'he454));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdr(`SHS_ADR_TBC);
    chk("count reset", rd, 32'h0);
    rdr(8'h14);
    chk("unmapped", rr, `SHS_RESP_ERR);
    for (int r = 0; r < 32; r++) wr(8'h80 + 8'(4 * r), (gm[r] = $urandom));
    $display("test reset done");
    run(xf(3, 0, 5, `SHS_XO_STHX), 0, 1, 0);
    run(xf(3, 7, 5, `SHS_XO_STHX) | 32'h1, 0, 1, 0);
    run(xf(4, 7, 5, `SHS_XO_STHUX), 0, 1, 0);
    run(xf(4, 0, 9, `SHS_XO_STHUX), 0, 1, 0);
    run({`SHS_OPC_STMW, 5'd29, 5'd7, 16'hfff8}, 0, 1, 0);
    run({`SHS_OPC_STMW, 5'd0, 5'd0, 16'h0010}, 0, 1, 0);
    run(xf(30, 0, 0, `SHS_XO_STSWI), 0, 1, 0);
    run(xf(31, 6, 5, `SHS_XO_STSWI), 0, 1, 0);
    wr(`SHS_ADR_TBC, 32'h6);
    run(xf(2, 7, 5, `SHS_XO_STSWX), 7'h6, 1, 0);
    wr(`SHS_ADR_TBC, 32'h0);
    run(xf(2, 7, 5, `SHS_XO_STSWX), 7'h0, 1, 0);
    berr <= 1'b1;
    run(xf(2, 7, 5, `SHS_XO_STSWX), 7'h0, 1, 3);
    berr <= 1'b0;
    $display("test forms done");
    // zone checks in both privilege levels, then a translation miss
    for (int u = 0; u < 2; u++) begin
      for (int z = 0; z < 3; z++) begin
        wr(`SHS_ADR_CTRL, 32'(1 + 2 * u));
        xlat_zone_i <= 2'(z);
        f = (z == 1) || (z == 0 && u == 1);
        run(xf(3, 7, 5, `SHS_XO_STHX), 0, !f, f ? 1 : 0);
      end
    end
    xlat_hit_i <= 1'b0;
    run(xf(3, 7, 5, `SHS_XO_STHX), 0, 0, 2);
    run(xf(2, 7, 5, `SHS_XO_STSWX), 0, 0, 0);
    wr(`SHS_ADR_CTRL, 32'h0);
    run(xf(3, 7, 5, `SHS_XO_STHX), 0, 1, 0);
    xlat_hit_i <= 1'b1;
    $display("test faults done");
    for (int i = 0; i < 24; i++) begin
      x = $urandom;
      ins = xf(x[4:0], x[9:5], x[14:10], `SHS_XO_STHX);
      if (i % 4 == 1) ins = {`SHS_OPC_STMW, x[4:0], x[9:5], x[31:16]};
      if (i % 4 == 2) ins[10:1] = `SHS_XO_STSWI;
      if (i % 4 == 3) ins[10:1] = `SHS_XO_STSWX;
      wr(`SHS_ADR_TBC, {25'h0, x[22:16]});
      run(ins, x[22:16], 1, 0);
    end
    for (int r = 0; r < 32; r++) begin
      rdr(8'h80 + 8'(4 * r));
      chk("register", rd, gm[r]);
    end
    $display("test random done");
    final_report();
  end
endmodule
